// >>> hdl/sram_core_pkg.sv
package sram_core_pkg;

   // Word width of one beat on either data bus; the wider variant uses 36.
   localparam int DATA_W = 18;
   // Address width of one internal array; 256K words each.
   localparam int ADDR_W = 18;
   // One byte lane is nine bits wide, each with its own byte select.
   localparam int BYTE_W = 9;
   // Words in one burst, one from each internal array.
   localparam int BEATS = 4;
   // One CLOCK cycle is one half of the K period.
   // K rise is phase 0 and the inverted clock rise is phase 1.
   localparam logic PHASE_K_RISE = 1'b0;
   localparam logic PHASE_KN_RISE = 1'b1;
   // Read latency in half periods of K, from the start to the first word.
   localparam int LAT_HALF_PLL_ON = 5;
   localparam int LAT_HALF_PLL_OFF = 2;
   // Wait loaded into a read slot; the buffer register adds one and the
   // emitting cycle another, so the slot waits the latency less two.
   localparam logic [2:0] DUE_PLL_ON = 3'(LAT_HALF_PLL_ON - 2);
   localparam logic [2:0] DUE_PLL_OFF = 3'(LAT_HALF_PLL_OFF - 2);
   // Write beats are captured two to five half periods after the start.
   localparam int WR_TRACK = 5;

   typedef enum logic [1:0] {
      LAST_IDLE,
      LAST_READ,
      LAST_WRITE
   } last_e;

endpackage

// >>> hdl/skid_buffer2.sv
`timescale 1ns/1ps
`default_nettype none

// Two-entry buffer: an output register and one skid register behind it.
module skid_buffer2 #(
   parameter int W = 18
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);

   typedef struct packed {
      logic         ov;
      logic [W-1:0] od;
      logic         sv;
      logic [W-1:0] sd;
   } buf_s;

   buf_s q;
   buf_s d;

   always_comb begin
      d = q;
      if (q.ov == 1'b0 || out_ready == 1'b1) begin
         if (q.sv == 1'b1) begin
            d.od = q.sd;
            d.sv = 1'b0;
         end else begin
            d.ov = in_valid;
            d.od = in_valid ? in_data : q.od;
         end
      end else if (in_valid == 1'b1 && q.sv == 1'b0) begin
         d.sv = 1'b1;
         d.sd = in_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // A full skid register is the only thing that refuses a word.
   assign in_ready = ~q.sv;
   assign out_valid = q.ov;
   assign out_data = q.od;

endmodule // skid_buffer2

`default_nettype wire

// >>> hdl/burst_lane_array.sv
`timescale 1ns/1ps
`default_nettype none

// Four word arrays side by side, written all at once with byte enables.
module burst_lane_array #(
   parameter int AW = 18,
   parameter int DW = 18,
   parameter int NB = 2
) (
   input  wire logic              clk,
   input  wire logic              we,
   input  wire logic [AW-1:0]     waddr,
   input  wire logic [4*DW-1:0]   wdata,
   input  wire logic [4*NB-1:0]   wbe,
   input  wire logic [AW-1:0]     raddr,
   output logic      [4*DW-1:0]   rdata
);

   localparam int BW = DW / NB;

   logic [DW-1:0] mem [0:3][0:(1<<AW)-1];

   always_ff @(posedge clk) begin
      if (we) begin
         for (int l = 0; l < 4; l++) begin
            for (int b = 0; b < NB; b++) begin
               if (wbe[l*NB+b]) begin
                  mem[l][waddr][b*BW +: BW] <= wdata[l*DW + b*BW +: BW];
               end
            end
         end
      end
   end

   // Reads are combinational so forwarding can merge bytes in the same cycle.
   always_comb begin
      for (int l = 0; l < 4; l++) begin
         rdata[l*DW +: DW] = mem[l][raddr];
      end
   end

endmodule // burst_lane_array

`default_nettype wire

// >>> hdl/sep_port_burst4_sram_core.sv
// Contract
// - Reads use only the read port, writes only the write port.
// - Read and write addresses share one address bus, sampled at start.
// - Each access moves four words over two clock periods.
// - PLL on: first read word two and a half periods after start.
// - PLL off: first read word one period after start.
// - Accesses start only on K rises.
// - Inputs and read data pass through registers on both clock edges.
// - Four arrays; a burst takes one word from each.
// - Asserted read select at K rise captures the read address.
// - Lowest word first, then one word per half period until four.
// - A read on the next K rise after a read is ignored.
// - Reads every other K rise give gapless read data.
// - After deselect, bursts finish, then outputs float after next inverted rise.
// - Asserted write select at K rise starts a write with its address.
// - First word at next K rise, second at following inverted rise.
// - Four words are captured, then 72 bits committed at the address.
// - A write on the next K rise after a write is ignored.
// - A deselected write port ignores its inputs once bursts finish.
// - Deasserted byte select keeps that stored byte unchanged.
// - Both selected: read after idle or write, write after read.
// - A read right after a write returns the newest data.
// - Power-up leaves both ports deselected and outputs floating.
`timescale 1ns/1ps
`default_nettype none

module sep_port_burst4_sram_core #(
   parameter int DATA_W = sram_core_pkg::DATA_W,
   parameter int ADDR_W = sram_core_pkg::ADDR_W
) (
   input  wire logic                     CLOCK,
   input  wire logic                     RESET,
   input  wire logic                     READ_PORT_SELECT_N,
   input  wire logic                     WRITE_PORT_SELECT_N,
   input  wire logic [ADDR_W-1:0]        ADDRESS,
   input  wire logic [DATA_W-1:0]        WRITE_DATA,
   input  wire logic [DATA_W/9-1:0]      BYTE_WRITE_SELECT_N,
   input  wire logic                     PLL_DISABLE_N,
   output logic                          K_RISE,
   output logic [DATA_W-1:0]             READ_DATA,
   output logic                          READ_DATA_OE,
   output logic                          READ_VALID,
   input  wire logic                     READ_READY
);

   localparam int NB = DATA_W / sram_core_pkg::BYTE_W;

   if (DATA_W % sram_core_pkg::BYTE_W != 0 || NB < 1 || ADDR_W < 1) begin : g_check
      $error("DATA_W must be a multiple of nine and ADDR_W positive.");
   end

   typedef struct packed {
      logic                          s1_rps;
      logic                          s2_rps;
      logic                          s1_wps;
      logic                          s2_wps;
      logic                          s1_pll;
      logic                          s2_pll;
      logic [ADDR_W-1:0]             s1_addr;
      logic [ADDR_W-1:0]             s2_addr;
      logic [DATA_W-1:0]             s1_data;
      logic [DATA_W-1:0]             s2_data;
      logic [NB-1:0]                 s1_be_n;
      logic [NB-1:0]                 s2_be_n;
      logic                          phase;
      sram_core_pkg::last_e          last;
      logic [1:0]                    rd_valid;
      logic [1:0][2:0]               rd_due;
      logic [1:0][ADDR_W-1:0]        rd_addr;
      logic                          rd_head;
      logic                          rd_tail;
      logic [1:0]                    rd_beat;
      logic [sram_core_pkg::WR_TRACK-1:0] wr_sr;
      logic [ADDR_W-1:0]             wr_req_addr;
      logic [ADDR_W-1:0]             wr_addr;
      logic [2:0][DATA_W-1:0]        wr_word;
      logic [2:0][NB-1:0]            wr_be;
      logic [2:0]                    wr_have;
      logic                          oe;
   } core_s;

   core_s q;
   core_s d;

   logic                 k_rise;
   logic                 rd_start;
   logic                 wr_start;
   logic                 emit;
   logic                 accept;
   logic [DATA_W-1:0]    emit_word;
   logic                 buf_in_ready;
   logic                 buf_out_valid;
   logic                 mem_we;
   logic [4*DATA_W-1:0]  mem_wdata;
   logic [4*NB-1:0]      mem_wbe;
   logic [ADDR_W-1:0]    mem_raddr;
   logic [4*DATA_W-1:0]  mem_rdata;

   always_comb begin
      d = q;
      d.s1_rps  = READ_PORT_SELECT_N;
      d.s2_rps  = q.s1_rps;
      d.s1_wps  = WRITE_PORT_SELECT_N;
      d.s2_wps  = q.s1_wps;
      d.s1_pll  = PLL_DISABLE_N;
      d.s2_pll  = q.s1_pll;
      d.s1_addr = ADDRESS;
      d.s2_addr = q.s1_addr;
      d.s1_data = WRITE_DATA;
      d.s2_data = q.s1_data;
      d.s1_be_n = BYTE_WRITE_SELECT_N;
      d.s2_be_n = q.s1_be_n;
      d.phase   = ~q.phase;

      k_rise = (q.phase == sram_core_pkg::PHASE_K_RISE);
      rd_start = k_rise && !q.s2_rps && q.last != sram_core_pkg::LAST_READ
                 && q.rd_valid != 2'b11;
      wr_start = k_rise && !q.s2_wps && q.last != sram_core_pkg::LAST_WRITE
                 && !rd_start;
      if (k_rise) begin
         if (rd_start) begin
            d.last = sram_core_pkg::LAST_READ;
         end else if (wr_start) begin
            d.last = sram_core_pkg::LAST_WRITE;
         end else begin
            d.last = sram_core_pkg::LAST_IDLE;
         end
      end

      for (int i = 0; i < 2; i++) begin
         if (q.rd_valid[i] && q.rd_due[i] != 3'h0) begin
            d.rd_due[i] = q.rd_due[i] - 3'h1;
         end
      end

      if (rd_start) begin
         d.rd_valid[q.rd_tail] = 1'b1;
         d.rd_addr[q.rd_tail] = q.s2_addr;
         d.rd_due[q.rd_tail] = q.s2_pll ? sram_core_pkg::DUE_PLL_ON
                                        : sram_core_pkg::DUE_PLL_OFF;
         d.rd_tail = ~q.rd_tail;
      end

      emit = q.rd_valid[q.rd_head] && q.rd_due[q.rd_head] == 3'h0;
      accept = emit && buf_in_ready;
      mem_raddr = q.rd_addr[q.rd_head];
      emit_word = mem_rdata[q.rd_beat*DATA_W +: DATA_W];
      for (int b = 0; b < 3; b++) begin
         if (q.wr_have[b] && q.rd_beat == 2'(b) && q.wr_addr == mem_raddr) begin
            for (int y = 0; y < NB; y++) begin
               if (q.wr_be[b][y]) begin
                  emit_word[y*sram_core_pkg::BYTE_W +: sram_core_pkg::BYTE_W] =
                     q.wr_word[b][y*sram_core_pkg::BYTE_W +: sram_core_pkg::BYTE_W];
               end
            end
         end
      end
      if (accept) begin
         d.rd_beat = q.rd_beat + 2'h1;
         if (q.rd_beat == 2'h3) begin
            d.rd_valid[q.rd_head] = 1'b0;
            d.rd_head = ~q.rd_head;
         end
      end

      d.wr_sr = {q.wr_sr[sram_core_pkg::WR_TRACK-2:0], wr_start};
      if (wr_start) begin
         d.wr_req_addr = q.s2_addr;
      end
      for (int b = 0; b < 3; b++) begin
         if (q.wr_sr[b+1]) begin
            d.wr_word[b] = q.s2_data;
            d.wr_be[b] = ~q.s2_be_n;
            d.wr_have[b] = 1'b1;
         end
      end
      if (q.wr_sr[1]) begin
         d.wr_addr = q.wr_req_addr;
      end
      mem_we = q.wr_sr[4];
      mem_wdata = {q.s2_data, q.wr_word[2], q.wr_word[1], q.wr_word[0]};
      mem_wbe = {~q.s2_be_n, q.wr_be[2], q.wr_be[1], q.wr_be[0]};
      if (mem_we) begin
         d.wr_have = 3'h0;
      end

      d.oe = buf_out_valid || (q.oe && q.phase != sram_core_pkg::PHASE_KN_RISE);
   end

   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         q <= '0;
         q.s1_rps <= 1'b1;
         q.s2_rps <= 1'b1;
         q.s1_wps <= 1'b1;
         q.s2_wps <= 1'b1;
         q.s1_pll <= 1'b1;
         q.s2_pll <= 1'b1;
      end else begin
         q <= d;
      end
   end

   burst_lane_array #(
      .AW (ADDR_W),
      .DW (DATA_W),
      .NB (NB)
   ) u_array (
      .clk   (CLOCK),
      .we    (mem_we),
      .waddr (q.wr_addr),
      .wdata (mem_wdata),
      .wbe   (mem_wbe),
      .raddr (mem_raddr),
      .rdata (mem_rdata)
   );

   // A stall by the receiver holds the burst in place rather than losing words.
   // one word per half period
   skid_buffer2 #(
      .W (DATA_W)
   ) u_out (
      .clk       (CLOCK),
      .rst       (RESET),
      .in_valid  (emit),
      .in_ready  (buf_in_ready),
      .in_data   (emit_word),
      .out_valid (buf_out_valid),
      .out_ready (READ_READY),
      .out_data  (READ_DATA)
   );

   assign READ_VALID = buf_out_valid;
   assign READ_DATA_OE = buf_out_valid | q.oe;
   assign K_RISE = ~q.phase;

   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (RESET);

   a_read_no_back: assert property (
      rd_start |-> ##2 !rd_start)
      else $error("Read started on consecutive K rises.");

   a_write_no_back: assert property (
      wr_start |-> ##2 !wr_start)
      else $error("Write started on consecutive K rises.");

   a_latency_pll_on: assert property (
      (rd_start && q.s2_pll && q.rd_valid == 2'b00) |-> !emit [*4] ##1 emit)
      else $error("First read word not emitted at the PLL on latency.");

   a_latency_pll_off: assert property (
      (rd_start && !q.s2_pll && q.rd_valid == 2'b00) |=> emit)
      else $error("First read word not emitted at the PLL off latency.");

   a_write_commit: assert property (
      wr_start |-> ##5 mem_we)
      else $error("Write burst not committed five half periods after start.");

   a_write_idle: assert property (
      mem_we |-> $past(wr_start, 5))
      else $error("Array written without a started write.");

   a_arb_read_first: assert property (
      (k_rise && !q.s2_rps && !q.s2_wps && q.last == sram_core_pkg::LAST_IDLE
       && q.rd_valid != 2'b11) |-> rd_start && !wr_start)
      else $error("Read did not win arbitration after idle.");

   a_arb_write_next: assert property (
      (k_rise && !q.s2_rps && !q.s2_wps && q.last == sram_core_pkg::LAST_READ)
      |-> wr_start)
      else $error("Write did not win arbitration after a read.");

   a_burst_wrap: assert property (
      (accept && q.rd_beat == 2'h3) |=> q.rd_beat == 2'h0 && !$stable(q.rd_head))
      else $error("Burst did not end after its fourth word.");

   a_float_after: assert property (
      (!buf_out_valid && q.phase == sram_core_pkg::PHASE_KN_RISE) |=> !q.oe)
      else $error("Read outputs still driven after the inverted rise.");

endmodule // sep_port_burst4_sram_core

`default_nettype wire

// >>> verification/mem_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

// Controller side of the pins; every pin changes just after a falling edge.
module mem_ctrl_model #(
   parameter int AW = 6
) (
   input  wire logic     clk,
   input  wire logic     k_rise,
   output logic          rd_sel_n,
   output logic          wr_sel_n,
   output logic [AW-1:0] addr,
   output logic [17:0]   wdata,
   output logic [1:0]    byte_sel_n
);
   logic [17:0] wd_q [0:15];
   logic [1:0]  be_q [0:15];
   logic [15:0] due = '0;
   int          cyc = 0;

   initial begin
      rd_sel_n = 1'b1;
      wr_sel_n = 1'b1;
      addr = '0;
      wdata = '0;
      byte_sel_n = 2'h3;
   end

   always @(negedge clk) begin
      if (due[cyc%16]) begin
         wdata <= wd_q[cyc%16];
         byte_sel_n <= be_q[cyc%16];
         due[cyc%16] <= 1'b0;
      end else begin
         // A released data bus must not look like it still holds the last word.
         wdata <= ~wdata;
         byte_sel_n <= 2'h3;
      end
      cyc <= cyc + 1;
   end

   task automatic issue(input logic rd, input logic wr, input logic [AW-1:0] a,
                        input logic [71:0] d, input logic [7:0] be_n);
      @(negedge clk);
      while (k_rise !== 1'b1) @(negedge clk);
      rd_sel_n = ~rd;
      wr_sel_n = ~wr;
      addr = a;
      // A write on the K rise right after a write finds the data bus still
      // carrying the first burst, so it sends no words of its own.
      if (wr && !due[(cyc+2)%16]) begin
         for (int k = 0; k < 4; k++) begin
            wd_q[(cyc+2+k)%16] = d[18*k +: 18];
            be_q[(cyc+2+k)%16] = be_n[2*k +: 2];
            due[(cyc+2+k)%16] = 1'b1;
         end
      end
      @(negedge clk);
      rd_sel_n = 1'b1;
      wr_sel_n = 1'b1;
      addr = ~a;
   endtask
endmodule // mem_ctrl_model

`default_nettype wire

// >>> verification/sep_port_burst4_sram_core_test.sv
`timescale 1ns/1ps
`default_nettype none

module sep_port_burst4_sram_core_test;
   localparam int AW = 6;
   logic          clock = 1'b0;
   logic          reset = 1'b1;
   logic          pll_disable_n = 1'b1;
   logic          read_ready = 1'b1;
   logic          rd_sel_n, wr_sel_n, k_rise, read_valid, read_oe;
   logic [AW-1:0] addr;
   logic [17:0]   wdata, read_data;
   logic [1:0]    byte_sel_n;
   logic [71:0]   mem [0:63];
   int            error_cnt = 0;
   int            num_checks = 0;
   int            nc = 0;

   mem_ctrl_model #(.AW(AW)) u_ctrl (.clk(clock), .k_rise(k_rise), .rd_sel_n(rd_sel_n),
      .wr_sel_n(wr_sel_n), .addr(addr), .wdata(wdata), .byte_sel_n(byte_sel_n));

   sep_port_burst4_sram_core #(.ADDR_W(AW)) u_dut (.CLOCK(clock), .RESET(reset),
      .READ_PORT_SELECT_N(rd_sel_n), .WRITE_PORT_SELECT_N(wr_sel_n), .ADDRESS(addr),
      .WRITE_DATA(wdata), .BYTE_WRITE_SELECT_N(byte_sel_n), .PLL_DISABLE_N(pll_disable_n),
      .K_RISE(k_rise), .READ_DATA(read_data), .READ_DATA_OE(read_oe),
      .READ_VALID(read_valid), .READ_READY(read_ready));

   initial forever #5 clock = ~clock;

   always @(posedge clock) begin
      nc <= nc + 1;
      if (nc == 3000) begin
         error_cnt++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic check(input string what, input logic [71:0] exp, input logic [71:0] seen);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic logic [71:0] pat(input logic [7:0] s);
      return {s, 10'h155, s, 10'h0aa, ~s, 10'h0f0, ~s, 10'h30f};
   endfunction

   // Gathers one burst; lat counts cycles from t0 to the first word seen.
   task automatic collect(input int t0, output logic [71:0] w, output int lat, output int gaps);
      int n;
      n = 0;
      gaps = 0;
      lat = -1;
      w = 'x;
      for (int i = 0; i < 40; i++) begin
         if (read_valid === 1'b1 && lat < 0) lat = nc - t0;
         if (read_valid === 1'b1 && read_ready === 1'b1) begin
            w[18*n +: 18] = read_data;
            n++;
         end else if (lat >= 0) gaps++;
         @(negedge clock);
         if (n == 4) break;
      end
   endtask

   task automatic gap();
      u_ctrl.issue(1'b0, 1'b0, '0, '0, 8'hff);
   endtask

   task automatic wr(input logic [AW-1:0] a, input logic [71:0] d, input logic [7:0] be_n);
      u_ctrl.issue(1'b0, 1'b1, a, d, be_n);
      for (int k = 0; k < 8; k++) if (!be_n[k]) mem[a][9*k +: 9] = d[9*k +: 9];
   endtask

   task automatic rd(input logic [AW-1:0] a, input int exp_lat);
      logic [71:0] w;
      int          l, g;
      u_ctrl.issue(1'b1, 1'b0, a, '0, 8'hff);
      collect(nc - 1, w, l, g);
      check("read latency", exp_lat, l);
      check("read burst", mem[a], w);
   endtask

   task automatic t_basic();
      wr(6'h01, pat(8'h11), 8'h00);
      gap();
      wr(6'h02, pat(8'h22), 8'h00);
      gap();
      wr(6'h03, pat(8'h33), 8'h00);
      rd(6'h01, 7);
      rd(6'h02, 7);
      repeat (4) @(negedge clock);
      check("oe released", 1'b0, read_oe);
      wr(6'h01, pat(8'h5c), 8'h5a);
      gap();
      rd(6'h01, 7);
   endtask

   task automatic t_pll_off();
      pll_disable_n = 1'b0;
      repeat (6) @(negedge clock);
      rd(6'h02, 4);
      wr(6'h02, pat(8'h6d), 8'h96);
      rd(6'h02, 4);
      pll_disable_n = 1'b1;
      repeat (6) @(negedge clock);
   endtask

   task automatic t_read_pairs();
      logic [71:0] w;
      int          l, g, extra;
      u_ctrl.issue(1'b1, 1'b0, 6'h01, '0, 8'hff);
      u_ctrl.issue(1'b1, 1'b0, 6'h02, '0, 8'hff);
      collect(nc - 3, w, l, g);
      check("first of pair", mem[6'h01], w);
      extra = 0;
      repeat (16) begin
         @(negedge clock);
         if (read_valid === 1'b1) extra++;
      end
      check("ignored read", 0, extra);
      u_ctrl.issue(1'b1, 1'b0, 6'h02, '0, 8'hff);
      gap();
      u_ctrl.issue(1'b1, 1'b0, 6'h03, '0, 8'hff);
      collect(nc - 5, w, l, g);
      check("stream first", mem[6'h02], w);
      collect(nc, w, l, g);
      check("stream second", mem[6'h03], w);
      check("stream gap", 0, l + g);
   endtask

   task automatic t_write_pairs();
      wr(6'h04, pat(8'h44), 8'h00);
      u_ctrl.issue(1'b0, 1'b1, 6'h02, pat(8'hee), 8'h00);
      gap();
      rd(6'h02, 7);
      rd(6'h04, 7);
      wr(6'h03, pat(8'h77), 8'h00);
      rd(6'h03, 7);
   endtask

   task automatic t_arbitrate();
      logic [71:0] w;
      int          l, g;
      repeat (4) gap();
      u_ctrl.issue(1'b1, 1'b1, 6'h04, pat(8'h99), 8'h00);
      collect(nc - 1, w, l, g);
      check("idle read first", mem[6'h04], w);
      u_ctrl.issue(1'b1, 1'b0, 6'h01, '0, 8'hff);
      // Both selected right after a read: the write must win.
      u_ctrl.issue(1'b1, 1'b1, 6'h04, pat(8'hab), 8'h00);
      mem[6'h04] = pat(8'hab);
      u_ctrl.issue(1'b1, 1'b0, 6'h04, '0, 8'hff);
      collect(nc - 5, w, l, g);
      check("read before write", mem[6'h01], w);
      collect(nc, w, l, g);
      check("write after read", mem[6'h04], w);
   endtask

   task automatic t_stall();
      logic [71:0] w;
      int          l, g;
      u_ctrl.issue(1'b1, 1'b0, 6'h03, '0, 8'hff);
      read_ready = 1'b0;
      for (int i = 0; i < 20 && read_valid !== 1'b1; i++) @(negedge clock);
      repeat (6) @(negedge clock);
      check("held word", mem[6'h03][17:0], read_data);
      check("oe while held", 1'b1, read_oe);
      read_ready = 1'b1;
      collect(nc, w, l, g);
      check("stalled burst", mem[6'h03], w);
   endtask

   initial begin
      repeat (5) @(negedge clock);
      check("reset phase", 1'b1, k_rise);
      check("reset oe", 1'b0, read_oe);
      check("reset valid", 1'b0, read_valid);
      reset = 1'b0;
      repeat (4) @(negedge clock);
      t_basic();
      t_pll_off();
      t_read_pairs();
      t_write_pairs();
      t_arbitrate();
      t_stall();
      complete_run();
   end
endmodule // sep_port_burst4_sram_core_test

`default_nettype wire
